// ===== sar_adc_pkg.sv
package sar_adc_pkg;

   // Byte addresses of the registers on the Avalon-MM slave.
   localparam logic [7:0] OFS_STATUS_CONTROL = 8'h3C;
   localparam logic [7:0] OFS_RESULT = 8'h40;
   localparam logic [7:0] OFS_CLOCK = 8'h44;
   localparam logic [7:0] OFS_PORT_DATA = 8'h48;
   localparam logic [7:0] OFS_PORT_DIR = 8'h4C;

   // Width of the bus data and of the registers behind it.
   localparam int BUS_W = 32;
   localparam int REG_W = 8;
   localparam int NUM_CH = 4;

   // Field positions inside the status and control register.
   localparam int CFG_MSB = 6;
   localparam int CFG_LSB = 0;

   // Field positions inside the converter clock register.
   localparam int DIV_MSB = 7;
   localparam int DIV_LSB = 5;
   localparam logic [4:0] CLOCK_LOW_ZERO = 5'h00;

   // Field positions of the shared pins inside the port registers.
   localparam int PORT_MSB = 3;
   localparam int PORT_LSB = 0;
   localparam logic [3:0] PORT_HIGH_ZERO = 4'h0;

   // Channel select codes.
   localparam logic [4:0] CH_LAST_EXT = 5'h03;
   localparam logic [4:0] CH_REF_HIGH = 5'h1D;
   localparam logic [4:0] CH_REF_LOW = 5'h1E;
   localparam logic [4:0] CH_POWER_OFF = 5'h1F;

   // Converter clock ticks within one conversion.
   localparam logic [3:0] TICK_FIRST = 4'h0;
   localparam logic [3:0] TICK_MSB_TRIAL = 4'h7;
   localparam logic [3:0] TICK_FIRST_DECIDE = 4'h8;
   localparam logic [3:0] TICK_LAST = 4'hF;
   localparam logic [3:0] TICK_ONE = 4'h1;

   // Successive approximation codes.
   localparam logic [7:0] SAR_CLEAR = 8'h00;
   localparam logic [7:0] SAR_MSB = 8'h80;
   localparam logic [7:0] RESULT_RESET = 8'h00;

   // Prescaler codes and the counter masks that they select.
   localparam logic [2:0] DIV_RESET = 3'h0;
   localparam logic [2:0] DIV_CODE_1 = 3'h0;
   localparam logic [2:0] DIV_CODE_2 = 3'h1;
   localparam logic [2:0] DIV_CODE_4 = 3'h2;
   localparam logic [2:0] DIV_CODE_8 = 3'h3;
   localparam logic [3:0] DIV_MASK_1 = 4'h0;
   localparam logic [3:0] DIV_MASK_2 = 4'h1;
   localparam logic [3:0] DIV_MASK_4 = 4'h3;
   localparam logic [3:0] DIV_MASK_8 = 4'h7;
   localparam logic [3:0] DIV_MASK_16 = 4'hF;
   localparam logic [3:0] DIV_CNT_RESET = 4'h0;

   // Writable part of the status and control register, bits 6 to 0.
   typedef struct packed {
      logic conversion_interrupt_enable;
      logic continuous_conversion_bit;
      logic [4:0] ch;
   } converter_cfg_t;

   localparam converter_cfg_t CFG_RESET = '{conversion_interrupt_enable: 1'b0, continuous_conversion_bit: 1'b0, ch: CH_POWER_OFF};

   // Sequencer states.
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_ARMED = 3'b010,
      ST_CONV = 3'b100
   } conv_state_t;

endpackage : sar_adc_pkg

// ===== adc_clk_prescaler.sv
`timescale 1ns/10ps
`default_nettype none

module adc_clk_prescaler (
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic [2:0] div_code_i,
   output logic tick_o
);

   logic [3:0] cnt_r;

   // Maps the prescaler code onto a counter mask; any code with the top bit set divides by 16.
   function automatic logic [3:0] div_mask(input logic [2:0] code);
      logic [3:0] m;
      m = sar_adc_pkg::DIV_MASK_16;
      unique case (code)
         sar_adc_pkg::DIV_CODE_1: m = sar_adc_pkg::DIV_MASK_1;
         sar_adc_pkg::DIV_CODE_2: m = sar_adc_pkg::DIV_MASK_2;
         sar_adc_pkg::DIV_CODE_4: m = sar_adc_pkg::DIV_MASK_4;
         sar_adc_pkg::DIV_CODE_8: m = sar_adc_pkg::DIV_MASK_8;
         default: m = sar_adc_pkg::DIV_MASK_16;
      endcase
      return m;
   endfunction : div_mask

   // Free running counter; a ratio change takes effect at once, as the new mask is applied to the running count.
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt_r <= sar_adc_pkg::DIV_CNT_RESET;
      end else begin
         cnt_r <= cnt_r + 4'h1;
      end
   end

   // One bus cycle pulse marks each rising edge of the converter clock.
   assign tick_o = ((cnt_r & div_mask(div_code_i)) == div_mask(div_code_i));

endmodule : adc_clk_prescaler

`default_nettype wire

// ===== sar_adc_sequencer.sv
`timescale 1ns/10ps
`default_nettype none

module sar_adc_sequencer (
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic [7:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic comparator_i,
   output logic [7:0] dac_code_o,
   output logic track_o,
   output logic converter_on_o,
   output logic [3:0] mux_sel_o,
   output logic ref_high_sel_o,
   output logic ref_low_sel_o,
   output logic conv_irq_o,
   input wire logic [3:0] pin_i,
   output logic [3:0] pin_o,
   output logic [3:0] pin_oe_o
);

   // Registers behind the bus.
   sar_adc_pkg::converter_cfg_t cfg_r;
   logic conversion_complete_flag_r;
   logic irq_r;
   logic [7:0] result_r;
   logic [2:0] converter_clock_divider_r;
   logic [3:0] port_latch_r;
   logic [3:0] port_dir_r;

   // Bus slave state.
   logic ack_r;
   logic [31:0] rdata_r;
   logic [7:0] rd_byte;

   // Sequencer state.
   sar_adc_pkg::conv_state_t state_r;
   logic [3:0] tick_idx_r;
   logic [7:0] sar_r;
   logic complete_seen_r;

   // Shared pin synchroniser.
   logic [3:0] pin_meta_r;
   logic [3:0] pin_sync_r;

   // Decoded strobes and helpers.
   logic req;
   logic wr_acc;
   logic rd_acc;
   logic wr_status;
   logic wr_clock;
   logic wr_port_data;
   logic wr_port_dir;
   logic rd_result;
   logic conv_tick;
   logic last_tick;
   logic done;
   logic [3:0] sel;
   logic [3:0] port_read;
   logic [2:0] decide_bit;
   logic [7:0] sar_step_val;
   logic [7:0] wbyte;
   sar_adc_pkg::converter_cfg_t cfg_wr;

   // One-hot channel decode; codes outside the external channels route no pin.
   function automatic logic [3:0] chan_onehot(input logic [4:0] ch);
      logic [3:0] oh;
      oh = 4'h0;
      if (ch <= sar_adc_pkg::CH_LAST_EXT) begin
         oh[ch[1:0]] = 1'b1;
      end
      return oh;
   endfunction : chan_onehot

   // Decides one trial bit and places the trial for the next lower bit.
   function automatic logic [7:0] sar_step(input logic [7:0] code, input logic [2:0] b,
                                           input logic keep);
      logic [7:0] c;
      c = code;
      if (!keep) begin
         c[b] = 1'b0;
      end
      if (b != 3'h0) begin
         c[b - 3'h1] = 1'b1;
      end
      return c;
   endfunction : sar_step

   // Merges written port bits while the bit of the converter pin keeps its old value.
   function automatic logic [3:0] port_merge(input logic [3:0] old, input logic [3:0] wr,
                                             input logic [3:0] keep);
      return (old & keep) | (wr & ~keep);
   endfunction : port_merge

   // The converter clock divider.
   adc_clk_prescaler u_prescaler (
      .mclk_i(mclk_i),
      .rst_b_i(rst_b_i),
      .div_code_i(converter_clock_divider_r),
      .tick_o(conv_tick)
   );

   // Every access waits exactly one cycle; the second cycle is the accept edge.
   assign req = avs_read_i | avs_write_i;
   assign avs_waitrequest_o = req & ~ack_r;
   assign wr_acc = avs_write_i & ack_r & avs_byteenable_i[0];
   assign rd_acc = avs_read_i & ack_r;
   assign wbyte = avs_writedata_i[7:0];

   // The written byte viewed as the status and control fields.
   assign cfg_wr = sar_adc_pkg::converter_cfg_t'(
      wbyte[sar_adc_pkg::CFG_MSB:sar_adc_pkg::CFG_LSB]);

   // Address decode of the accepted access.
   assign wr_status = wr_acc & (avs_address_i == sar_adc_pkg::OFS_STATUS_CONTROL);
   assign wr_clock = wr_acc & (avs_address_i == sar_adc_pkg::OFS_CLOCK);
   assign wr_port_data = wr_acc & (avs_address_i == sar_adc_pkg::OFS_PORT_DATA);
   assign wr_port_dir = wr_acc & (avs_address_i == sar_adc_pkg::OFS_PORT_DIR);
   assign rd_result = rd_acc & (avs_address_i == sar_adc_pkg::OFS_RESULT);

   // Wait state generator.
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= req & ~ack_r;
      end
   end

   // Channel routing and the pin read path.
   assign sel = chan_onehot(cfg_r.ch);
   always_comb begin
      for (int i = 0; i < sar_adc_pkg::NUM_CH; i++) begin
         if (port_dir_r[i]) begin
            port_read[i] = port_latch_r[i];
         end else if (sel[i]) begin
            port_read[i] = 1'b0;
         end else begin
            port_read[i] = pin_sync_r[i];
         end
      end
   end

   // Read multiplexer; unmapped addresses read zero.
   always_comb begin
      unique case (avs_address_i)
         sar_adc_pkg::OFS_STATUS_CONTROL: rd_byte = {conversion_complete_flag_r & ~cfg_r.conversion_interrupt_enable,
                                                     cfg_r};
         sar_adc_pkg::OFS_RESULT: rd_byte = result_r;
         sar_adc_pkg::OFS_CLOCK: rd_byte = {converter_clock_divider_r,
                                            sar_adc_pkg::CLOCK_LOW_ZERO};
         sar_adc_pkg::OFS_PORT_DATA: rd_byte = {sar_adc_pkg::PORT_HIGH_ZERO, port_read};
         sar_adc_pkg::OFS_PORT_DIR: rd_byte = {sar_adc_pkg::PORT_HIGH_ZERO, port_dir_r};
         default: rd_byte = 8'h00;
      endcase
   end

   // Read data is captured in the wait cycle and stands at the accept edge.
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rdata_r <= 32'h00000000;
      end else if (avs_read_i & ~ack_r) begin
         rdata_r <= 32'(rd_byte);
      end
   end
   assign avs_readdata_o = rdata_r;

   // Writable fields of the status and control register.
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cfg_r <= sar_adc_pkg::CFG_RESET;
      end else if (wr_status) begin
         cfg_r <= cfg_wr;
      end
   end

   // Converter clock register.
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         converter_clock_divider_r <= sar_adc_pkg::DIV_RESET;
      end else if (wr_clock) begin
         converter_clock_divider_r <= wbyte[sar_adc_pkg::DIV_MSB:sar_adc_pkg::DIV_LSB];
      end
   end

   // Port data latch and direction; the converter pin ignores writes.
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         port_latch_r <= 4'h0;
         port_dir_r <= 4'h0;
      end else begin
         if (wr_port_data) begin
            port_latch_r <= port_merge(port_latch_r,
                                       wbyte[sar_adc_pkg::PORT_MSB:sar_adc_pkg::PORT_LSB],
                                       sel);
         end
         if (wr_port_dir) begin
            port_dir_r <= port_merge(port_dir_r,
                                     wbyte[sar_adc_pkg::PORT_MSB:sar_adc_pkg::PORT_LSB],
                                     sel);
         end
      end
   end

   // Two flip-flops bring the shared pins into the bus clock domain.
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pin_meta_r <= 4'h0;
         pin_sync_r <= 4'h0;
      end else begin
         pin_meta_r <= pin_i;
         pin_sync_r <= pin_meta_r;
      end
   end

   // Pin drivers: the converter pin is released to the analog input.
   assign pin_oe_o = port_dir_r & ~sel;
   assign pin_o = port_latch_r & ~sel;

   // Analog side controls.
   assign converter_on_o = (cfg_r.ch != sar_adc_pkg::CH_POWER_OFF);
   assign mux_sel_o = sel;
   assign ref_high_sel_o = (cfg_r.ch == sar_adc_pkg::CH_REF_HIGH);
   assign ref_low_sel_o = (cfg_r.ch == sar_adc_pkg::CH_REF_LOW);
   assign dac_code_o = sar_r;
   assign track_o = (state_r == sar_adc_pkg::ST_ARMED) |
                    ((state_r == sar_adc_pkg::ST_CONV) &
                     (tick_idx_r <= sar_adc_pkg::TICK_MSB_TRIAL));

   // The final tick ends a conversion unless a status write aborts it in the same cycle.
   assign last_tick = (state_r == sar_adc_pkg::ST_CONV) & conv_tick &
                      (tick_idx_r == sar_adc_pkg::TICK_LAST);
   assign done = last_tick & ~wr_status;
   assign decide_bit = 3'(sar_adc_pkg::TICK_LAST - tick_idx_r);
   assign sar_step_val = sar_step(sar_r, decide_bit, comparator_i);

   // Sequencer; a status write restarts from the next converter clock edge unless it selects power off, which returns to idle.
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_r <= sar_adc_pkg::ST_IDLE;
      end else if (wr_status) begin
         if (cfg_wr.ch == sar_adc_pkg::CH_POWER_OFF) begin
            state_r <= sar_adc_pkg::ST_IDLE;
         end else begin
            state_r <= sar_adc_pkg::ST_ARMED;
         end
      end else begin
         unique case (state_r)
            sar_adc_pkg::ST_IDLE: state_r <= sar_adc_pkg::ST_IDLE;
            sar_adc_pkg::ST_ARMED: begin
               if (conv_tick) begin
                  state_r <= sar_adc_pkg::ST_CONV;
               end
            end
            sar_adc_pkg::ST_CONV: begin
               if (last_tick & cfg_r.continuous_conversion_bit) begin
                  state_r <= sar_adc_pkg::ST_ARMED;
               end else if (last_tick) begin
                  state_r <= sar_adc_pkg::ST_IDLE;
               end
            end
            default: state_r <= sar_adc_pkg::ST_IDLE;
         endcase
      end
   end

   // Tick index of the next converter clock edge within the conversion.
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tick_idx_r <= sar_adc_pkg::TICK_FIRST;
      end else if ((state_r == sar_adc_pkg::ST_ARMED) & conv_tick & ~wr_status) begin
         tick_idx_r <= sar_adc_pkg::TICK_ONE;
      end else if ((state_r == sar_adc_pkg::ST_CONV) & conv_tick) begin
         tick_idx_r <= tick_idx_r + sar_adc_pkg::TICK_ONE;
      end
   end

   // Trial register: tracks through tick 6, MSB trial at 7, bit decisions at 8 to 15.
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sar_r <= sar_adc_pkg::SAR_CLEAR;
      end else if (wr_status | ((state_r == sar_adc_pkg::ST_ARMED) & conv_tick)) begin
         sar_r <= sar_adc_pkg::SAR_CLEAR;
      end else if ((state_r == sar_adc_pkg::ST_CONV) & conv_tick) begin
         if (tick_idx_r == sar_adc_pkg::TICK_MSB_TRIAL) begin
            sar_r <= sar_adc_pkg::SAR_MSB;
         end else if (tick_idx_r >= sar_adc_pkg::TICK_FIRST_DECIDE) begin
            sar_r <= sar_step_val;
         end
      end
   end

   // Result register takes every completed code, read or not.
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         result_r <= sar_adc_pkg::RESULT_RESET;
      end else if (done) begin
         result_r <= sar_step_val;
      end
   end

   // Remembers a completion in the read's wait cycle so a read of stale data keeps the flag.
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         complete_seen_r <= 1'b0;
      end else begin
         complete_seen_r <= done;
      end
   end

   // Completion flag: set wins over the clear by a result read.
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         conversion_complete_flag_r <= 1'b0;
      end else if (done & ~cfg_r.conversion_interrupt_enable) begin
         conversion_complete_flag_r <= 1'b1;
      end else if (rd_result & ~complete_seen_r) begin
         conversion_complete_flag_r <= 1'b0;
      end
   end

   // Interrupt request: set wins; a result read or a status write drops it.
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         irq_r <= 1'b0;
      end else if (done & cfg_r.conversion_interrupt_enable) begin
         irq_r <= 1'b1;
      end else if ((rd_result & ~complete_seen_r) | wr_status) begin
         irq_r <= 1'b0;
      end
   end
   assign conv_irq_o = irq_r;

endmodule : sar_adc_sequencer

`default_nettype wire

// ===== analog_source.sv
`timescale 1ns/10ps
`default_nettype none

module analog_source (
   input wire logic [31:0] level_i,
   input wire logic [3:0] mux_sel_i,
   input wire logic ref_high_i,
   input wire logic ref_low_i,
   input wire logic [7:0] dac_i,
   input wire logic [3:0] pin_out_i,
   input wire logic [3:0] pin_oe_i,
   output logic comparator_o,
   output logic [3:0] pin_level_o
);
   logic [7:0] vin;

   // The routed level is compared with the trial code; no route reads as ground.
   always_comb begin
      vin = 8'h00;
      if (ref_high_i) begin
         vin = 8'hFF;
      end
      for (int k = 0; k < 4; k++) begin
         if (mux_sel_i[k]) begin
            vin = level_i[8*k +: 8];
         end
      end
      comparator_o = (vin >= dac_i);
   end

   // A pin shows the block's value while driven, else the top bit of its level.
   always_comb begin
      for (int k = 0; k < 4; k++) begin
         pin_level_o[k] = pin_oe_i[k] ? pin_out_i[k] : level_i[8*k+7];
      end
   end
endmodule : analog_source

`default_nettype wire

// ===== sar_adc_sequencer_asserts.sv
`timescale 1ns/10ps
`default_nettype none

module sar_adc_sequencer_chk (
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic [7:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [3:0] avs_byteenable_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   input wire logic converter_on_o,
   input wire logic [3:0] mux_sel_o,
   input wire logic ref_high_sel_o,
   input wire logic ref_low_sel_o,
   input wire logic conv_irq_o,
   input wire logic [3:0] pin_o,
   input wire logic [3:0] pin_oe_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);

   // Bus phases and the accesses that clear the interrupt request.
   wire logic req = avs_read_i | avs_write_i;
   wire logic take = req & !avs_waitrequest_o;
   wire logic wr_ctl = take & avs_write_i & avs_byteenable_i[0]
      & (avs_address_i == sar_adc_pkg::OFS_STATUS_CONTROL);
   wire logic rd_res = take & avs_read_i & (avs_address_i == sar_adc_pkg::OFS_RESULT);

   sequence s_first;
      req && avs_waitrequest_o;
   endsequence
   sequence s_taken;
      take;
   endsequence

   a_wait_first: assert property ($rose(req) |-> s_first)
      else $error("request not held off in its first cycle");
   a_wait_once: assert property (s_first |=> s_taken)
      else $error("request not taken after one wait cycle");
   a_pin_released: assert property (((pin_oe_o | pin_o) & mux_sel_o) == 4'h0)
      else $error("selected pin still driven");
   a_one_channel: assert property ($onehot0({mux_sel_o, ref_high_sel_o, ref_low_sel_o}))
      else $error("more than one input routed");
   a_power_mux: assert property (!converter_on_o |-> mux_sel_o == 4'h0)
      else $error("input routed while powered off");
   a_irq_clear: assert property (wr_ctl |=> !conv_irq_o)
      else $error("interrupt kept after control write");
   a_irq_hold: assert property (conv_irq_o && !wr_ctl && !rd_res |=> conv_irq_o)
      else $error("interrupt dropped without cause");
   a_flag_masked: assert property (take && avs_read_i && !avs_address_i[6]
      && avs_address_i[5:0] == 6'h3C && avs_readdata_o[6] |-> !avs_readdata_o[7])
      else $error("complete flag set with interrupts on");
endmodule : sar_adc_sequencer_chk

bind sar_adc_sequencer sar_adc_sequencer_chk u_sar_adc_sequencer_chk (.mclk_i, .rst_b_i,
   .avs_address_i, .avs_read_i, .avs_write_i, .avs_byteenable_i, .avs_readdata_o,
   .avs_waitrequest_o, .converter_on_o, .mux_sel_o, .ref_high_sel_o, .ref_low_sel_o,
   .conv_irq_o, .pin_o, .pin_oe_o);

`default_nettype wire

// ===== tb_sar_adc_sequencer.sv
`timescale 1ns/10ps
`default_nettype none

module tb_sar_adc_sequencer;
   logic mclk_i = 1'h0;
   logic rst_b_i = 1'h0;
   logic [7:0] avs_address_i = 8'h00;
   logic avs_read_i = 1'h0;
   logic avs_write_i = 1'h0;
   logic [31:0] avs_writedata_i = 32'h00000000;
   logic [3:0] avs_byteenable_i = 4'hF;
   logic [31:0] avs_readdata_o;
   logic avs_waitrequest_o, comparator_i, track_o, converter_on_o, conv_irq_o;
   logic ref_high_sel_o, ref_low_sel_o;
   logic [7:0] dac_code_o;
   logic [3:0] mux_sel_o, pin_i, pin_o, pin_oe_o;
   logic [31:0] level = 32'hFF00A55A;
   logic [7:0] rd;
   int miscompares = 0;
   int check_count = 0;
   int cnt;
   int n;

   // Bus clock at 20 MHz.
   initial begin
      forever #25 mclk_i = ~mclk_i;
   end

   sar_adc_sequencer u_sar_adc_sequencer (.mclk_i, .rst_b_i, .avs_address_i, .avs_read_i,
      .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
      .comparator_i, .dac_code_o, .track_o, .converter_on_o, .mux_sel_o, .ref_high_sel_o,
      .ref_low_sel_o, .conv_irq_o, .pin_i, .pin_o, .pin_oe_o);

   analog_source u_analog_source (.level_i(level), .mux_sel_i(mux_sel_o),
      .ref_high_i(ref_high_sel_o), .ref_low_i(ref_low_sel_o), .dac_i(dac_code_o),
      .pin_out_i(pin_o), .pin_oe_i(pin_oe_o), .comparator_o(comparator_i),
      .pin_level_o(pin_i));

   task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // Waits for the edge at which waitrequest is sampled low.
   task wait_ack;
      do @(negedge mclk_i); while (avs_waitrequest_o !== 1'h0);
      @(posedge mclk_i);
   endtask : wait_ack

   task bus_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      avs_address_i <= a;
      avs_writedata_i <= {24'h000000, d};
      avs_write_i <= 1'h1;
      wait_ack();
      avs_write_i <= 1'h0;
   endtask : bus_write

   task bus_read(input logic [7:0] a);
      @(posedge mclk_i);
      avs_address_i <= a;
      avs_read_i <= 1'h1;
      wait_ack();
      rd = avs_readdata_o[7:0];
      avs_read_i <= 1'h0;
   endtask : bus_read

   // Counts clock edges from the taking edge until the request shows.
   task wait_irq;
      cnt = 0;
      @(negedge mclk_i);
      while (conv_irq_o !== 1'h1 && cnt < 300) begin
         @(negedge mclk_i);
         cnt++;
      end
   endtask : wait_irq

   task end_of_test;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_of_test

   // Watchdog well beyond the length of all tests.
   initial begin
      repeat (20000) @(posedge mclk_i);
      miscompares++;
      end_of_test();
   end

   // Main test sequence.
   initial begin
      repeat (16) @(posedge mclk_i);
      rst_b_i <= 1'h1;
      bus_read(sar_adc_pkg::OFS_STATUS_CONTROL);
      check("status", rd, 8'h1F);
      bus_read(sar_adc_pkg::OFS_RESULT);
      check("result", rd, 8'h00);
      bus_read(8'h50);
      check("unmapped", rd, 8'h00);
      $display("test reset done");
      for (int d = 0; d < 8; d++) begin
         n = (d > 3) ? 16 : (1 << d);
         bus_write(sar_adc_pkg::OFS_CLOCK, {d[2:0], 5'h00});
         bus_write(sar_adc_pkg::OFS_STATUS_CONTROL, {6'h10, d[1:0]});
         wait_irq();
         check("cycles", {7'h00, cnt >= 15*n+1 && cnt <= 16*n}, 8'h01);
         bus_read(sar_adc_pkg::OFS_STATUS_CONTROL);
         check("status", rd, {6'h10, d[1:0]});
         bus_read(sar_adc_pkg::OFS_RESULT);
         check("result", rd, level[8*(d%4) +: 8]);
         @(negedge mclk_i);
         check("irq", {7'h00, conv_irq_o}, 8'h00);
      end
      $display("test divider done");
      bus_write(sar_adc_pkg::OFS_CLOCK, 8'h00);
      bus_write(sar_adc_pkg::OFS_STATUS_CONTROL, 8'h41);
      repeat (20) @(negedge mclk_i);
      check("irq", {7'h00, conv_irq_o}, 8'h01);
      bus_write(sar_adc_pkg::OFS_STATUS_CONTROL, 8'h1F);
      @(negedge mclk_i);
      check("irq", {7'h00, conv_irq_o}, 8'h00);
      for (int r = 0; r < 2; r++) begin
         bus_write(sar_adc_pkg::OFS_STATUS_CONTROL, 8'h1D + r[7:0]);
         repeat (20) @(negedge mclk_i);
         check("dac", dac_code_o, r ? 8'h00 : 8'hFF);
         check("track", {7'h00, track_o}, 8'h00);
         check("refs", {6'h00, ref_high_sel_o, ref_low_sel_o}, r ? 8'h01 : 8'h02);
         check("on", {7'h00, converter_on_o}, 8'h01);
         bus_read(sar_adc_pkg::OFS_STATUS_CONTROL);
         check("flag", rd, 8'h9D + r[7:0]);
         bus_read(sar_adc_pkg::OFS_RESULT);
         check("ref", rd, r ? 8'h00 : 8'hFF);
         bus_read(sar_adc_pkg::OFS_STATUS_CONTROL);
         check("flag", rd, 8'h1D + r[7:0]);
      end
      $display("test flag done");
      bus_write(sar_adc_pkg::OFS_STATUS_CONTROL, 8'h21);
      repeat (20) @(negedge mclk_i);
      level[15:8] <= 8'h77;
      repeat (40) @(negedge mclk_i);
      bus_read(sar_adc_pkg::OFS_STATUS_CONTROL);
      check("flag", rd, 8'hA1);
      bus_read(sar_adc_pkg::OFS_RESULT);
      check("result", rd, 8'h77);
      level[15:8] <= 8'h11;
      repeat (40) @(negedge mclk_i);
      bus_read(sar_adc_pkg::OFS_STATUS_CONTROL);
      check("flag", rd, 8'hA1);
      bus_read(sar_adc_pkg::OFS_RESULT);
      check("result", rd, 8'h11);
      level[15:8] <= 8'h22;
      bus_write(sar_adc_pkg::OFS_STATUS_CONTROL, 8'h01);
      repeat (20) @(negedge mclk_i);
      level[15:8] <= 8'h44;
      repeat (40) @(negedge mclk_i);
      bus_read(sar_adc_pkg::OFS_RESULT);
      check("result", rd, 8'h22);
      $display("test continuous done");
      bus_write(sar_adc_pkg::OFS_STATUS_CONTROL, 8'h1F);
      bus_write(sar_adc_pkg::OFS_PORT_DIR, 8'h0F);
      bus_write(sar_adc_pkg::OFS_PORT_DATA, 8'h0F);
      bus_write(sar_adc_pkg::OFS_STATUS_CONTROL, 8'h02);
      @(negedge mclk_i);
      check("oe", {4'h0, pin_oe_o}, 8'h0B);
      check("pin", {4'h0, pin_o}, 8'h0B);
      check("mux", {4'h0, mux_sel_o}, 8'h04);
      bus_write(sar_adc_pkg::OFS_PORT_DATA, 8'h00);
      bus_write(sar_adc_pkg::OFS_PORT_DIR, 8'h00);
      // Released pins need two clocks to pass the synchroniser.
      repeat (2) @(negedge mclk_i);
      bus_read(sar_adc_pkg::OFS_PORT_DATA);
      check("port", rd, 8'h0C);
      bus_write(sar_adc_pkg::OFS_STATUS_CONTROL, 8'h1F);
      @(negedge mclk_i);
      check("oe", {4'h0, pin_oe_o}, 8'h04);
      check("on", {7'h00, converter_on_o}, 8'h00);
      bus_write(sar_adc_pkg::OFS_PORT_DIR, 8'h00);
      bus_write(sar_adc_pkg::OFS_STATUS_CONTROL, 8'h02);
      bus_read(sar_adc_pkg::OFS_PORT_DATA);
      check("port", rd, 8'h08);
      $display("test ports done");
      end_of_test();
   end
endmodule : tb_sar_adc_sequencer

`default_nettype wire
